// [rtl/irf_regs.vh]
// register map, field positions, reset values and limits of the reading filter
`ifndef IRF_REGS_VH
`define IRF_REGS_VH

// ==========================================================================
// address decode: addr[8]=0 selects a channel block, addr[7:6] the channel
// ==========================================================================
`define IRF_ADDR_W       9
`define IRF_GLOBAL_BIT   8
`define IRF_CH_MSB       7
`define IRF_CH_LSB       6
`define IRF_IDX_MSB      5
`define IRF_IDX_LSB      2

// per-channel word indices (byte address = ch*0x40 + idx*4)
`define IRF_IDX_CFG      4'h0
`define IRF_IDX_LIMIT    4'h1
`define IRF_IDX_FSCALE   4'h2
`define IRF_IDX_FILT     4'h3
`define IRF_IDX_MAX      4'h4
`define IRF_IDX_MIN      4'h5
`define IRF_IDX_RAW      4'h6
`define IRF_IDX_NAME0    4'h8

// global registers (byte addresses)
`define IRF_ADDR_STATUS  9'h100
`define IRF_ADDR_MASK    9'h104
`define IRF_ADDR_SHUT    9'h108
`define IRF_ADDR_MMRST   9'h10C

// ==========================================================================
// config word fields
// ==========================================================================
`define IRF_CFG_EN_BIT   0
`define IRF_CFG_UNIT_LSB 1
`define IRF_CFG_PTS_LSB  8
`define IRF_CFG_WIN_LSB  16

// status word fields: result[3:0], over-temp[7:4], restart[11:8]
`define IRF_ST_OT_LSB    4
`define IRF_ST_RS_LSB    8
`define IRF_ST_W         12

// ==========================================================================
// reset values and limits
// ==========================================================================
`define IRF_PTS_MIN      7'h02
`define IRF_PTS_MAX      7'h40
`define IRF_PTS_RST      7'h08
`define IRF_WIN_MIN      4'h1
`define IRF_WIN_MAX      4'hA
`define IRF_WIN_RST      4'hA
`define IRF_LIM_MAX      12'hBB7
`define IRF_UNIT_RST     2'h0
`define IRF_K_FRAC       8
`define IRF_PCT_SCALE    40'h0000000064

`endif

// [rtl/irf_top.v]
// per-input reading filter, over-temperature check and max/min capture
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "irf_regs.vh"

// Functional notes
// [RULE1] filter on: each reading smoothed; filter off: passed unchanged
// [RULE2] running average, exactly one result per incoming reading; a reading met by a parameter write to its input gives none
// [RULE3] control gets raw reading; max/min and result use filtered value
// [RULE4] one filter point per reading; time constant follows reading period
// [RULE5] filter points per input selectable 2..64, default 8
// [RULE6] slower reading period: filter still steps once per reading
// [RULE7] jump larger than window restarts the filter
// [RULE8] window is percent of full scale, 1..10, default 10
// [RULE9] any input above its limit shuts down all control outputs
// [RULE10] separate limit per input, checked independently
// [RULE11] limit 0 K (default) disables check; limit up to 2999 K
// [RULE12] per input highest and lowest reading since last capture reset
// [RULE13] max/min captured in the input's preferred units
// [RULE14] max/min always running, every reading compared to both extremes
// [RULE15] max/min cleared at reset, on parameter change, on reset request
// [RULE16] preferred units setting presented with setpoint and max/min
// [RULE17] each input holds a label of up to 15 characters
// [RULE18] update: f += (x - f)/N; restart loads reading directly
// [RULE19] filter off after reset; points or window change restarts filter
module irf_top #(
    parameter DATA_W = 24
) (
    input  wire                   i_clk,
    input  wire                   i_reset_n,
    input  wire                   i_ce,
    // register port
    input  wire [`IRF_ADDR_W-1:0] i_addr,
    input  wire [31:0]            i_wdata,
    input  wire                   i_we,
    input  wire                   i_re,
    output reg  [31:0]            o_rdata,
    // readings from the measurement front end
    input  wire                   i_rdg_valid,
    input  wire [1:0]             i_rdg_chan,
    input  wire [DATA_W-1:0]      i_rdg_value,
    input  wire [DATA_W-1:0]      i_rdg_kelvin,
    // filtered result stream
    output reg                    o_res_valid,
    output reg  [1:0]             o_res_chan,
    output reg  [DATA_W-1:0]      o_res_value,
    output reg  [1:0]             o_res_units,
    // unfiltered stream toward the control loops
    output reg                    o_ctl_valid,
    output reg  [1:0]             o_ctl_chan,
    output reg  [DATA_W-1:0]      o_ctl_value,
    output reg                    o_shutdown,
    output reg                    o_irq
);

    // ======================================================================
    // storage
    // ======================================================================
    reg                    en_r     [0:3];
    reg  [1:0]             unit_r   [0:3];
    reg  [6:0]             pts_r    [0:3];
    reg  [3:0]             win_r    [0:3];
    reg  [11:0]            lim_r    [0:3];
    reg  [DATA_W-1:0]      fs_r     [0:3];
    reg  [DATA_W-1:0]      filt_r   [0:3];
    reg  [DATA_W-1:0]      max_r    [0:3];
    reg  [DATA_W-1:0]      min_r    [0:3];
    reg  [DATA_W-1:0]      raw_r    [0:3];
    reg  [31:0]            name_r   [0:15];
    reg  [3:0]             primed_r;
    reg  [3:0]             mm_ok_r;
    reg  [3:0]             ot_r;
    reg  [`IRF_ST_W-1:0]   status_r;
    reg  [`IRF_ST_W-1:0]   mask_r;

    integer                k;

    // ======================================================================
    // bus decode
    // ======================================================================
    wire                   is_glob = i_addr[`IRF_GLOBAL_BIT];
    wire [1:0]             bch     = i_addr[`IRF_CH_MSB:`IRF_CH_LSB];
    wire [3:0]             bidx    = i_addr[`IRF_IDX_MSB:`IRF_IDX_LSB];
    wire                   wr_cfg  = i_we & ~is_glob & (bidx == `IRF_IDX_CFG);
    wire                   wr_lim  = i_we & ~is_glob &
                                     (bidx == `IRF_IDX_LIMIT);
    wire                   wr_fs   = i_we & ~is_glob &
                                     (bidx == `IRF_IDX_FSCALE);
    wire                   wr_name = i_we & ~is_glob & (bidx[3:2] == 2'h2);
    wire                   wr_mmr  = i_we & (i_addr == `IRF_ADDR_MMRST);
    wire                   wr_st   = i_we & (i_addr == `IRF_ADDR_STATUS);
    wire                   wr_mask = i_we & (i_addr == `IRF_ADDR_MASK);
    // any parameter of the addressed input
    wire                   par_chg = wr_cfg | wr_lim | wr_fs;

    // clamp written points and window into their legal ranges
    wire [6:0]             pts_w   = i_wdata[`IRF_CFG_PTS_LSB +: 7];
    wire [3:0]             win_w   = i_wdata[`IRF_CFG_WIN_LSB +: 4];
    wire [6:0]             pts_c   = (pts_w < `IRF_PTS_MIN) ? `IRF_PTS_MIN :
                                     (pts_w > `IRF_PTS_MAX) ? `IRF_PTS_MAX :
                                     pts_w;                        // RULE5
    wire [3:0]             win_c   = (win_w < `IRF_WIN_MIN) ? `IRF_WIN_MIN :
                                     (win_w > `IRF_WIN_MAX) ? `IRF_WIN_MAX :
                                     win_w;                        // RULE8
    wire [11:0]            lim_c   = (i_wdata[11:0] > `IRF_LIM_MAX) ?
                                     `IRF_LIM_MAX : i_wdata[11:0]; // RULE11

    // ======================================================================
    // filter datapath for the incoming channel
    // ======================================================================
    wire [1:0]             c       = i_rdg_chan;
    wire [DATA_W-1:0]      f_old   = filt_r[c];
    wire signed [DATA_W+1:0] diff  = $signed({{2{i_rdg_value[DATA_W-1]}},
                                              i_rdg_value}) -
                                     $signed({{2{f_old[DATA_W-1]}}, f_old});
    wire [DATA_W+1:0]      absd    = diff[DATA_W+1] ? (~diff + 1'b1) : diff;
    wire signed [DATA_W+1:0] divs  = $signed({{(DATA_W-5){1'b0}},
                                              pts_r[c]});
    // divide truncates toward zero, so a small residue can stay behind
    wire signed [DATA_W+1:0] step  = diff / divs;                  // RULE18
    wire signed [DATA_W+1:0] f_sum = $signed({{2{f_old[DATA_W-1]}}, f_old})
                                     + step;
    // jump test: |x - f| * 100 > full_scale * window_percent
    wire [39:0]            jump_l  = {{(38-DATA_W){1'b0}}, absd} *
                                     `IRF_PCT_SCALE;
    wire [39:0]            win_l   = {{(40-DATA_W){1'b0}}, fs_r[c]} *
                                     {36'h0, win_r[c]};
    wire                   jump    = jump_l > win_l;               // RULE7
    wire                   restart = ~primed_r[c] | jump;
    // filtered value produced this reading, once per reading
    wire [DATA_W-1:0]      f_new   = ~en_r[c] ? i_rdg_value :      // RULE1
                                     restart  ? i_rdg_value :      // RULE18
                                     f_sum[DATA_W-1:0];      // RULE4 RULE6
    // over-temperature test on the raw kelvin reading, whole kelvin limit
    wire [DATA_W+11:0]     lim_fx  = {{DATA_W{1'b0}}, lim_r[c]}
                                     << `IRF_K_FRAC;
    wire                   over    = (lim_r[c] != 12'h000) &&      // RULE11
                                     ({12'h000, i_rdg_kelvin} > lim_fx);
    wire                   take    = i_rdg_valid & ~(par_chg & (bch == c));

    // ======================================================================
    // configuration, name and per-channel state
    // ======================================================================
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (k = 0; k < 4; k = k + 1) begin
                en_r[k]   <= 1'b0;                                 // RULE19
                unit_r[k] <= `IRF_UNIT_RST;
                pts_r[k]  <= `IRF_PTS_RST;                         // RULE5
                win_r[k]  <= `IRF_WIN_RST;                         // RULE8
                lim_r[k]  <= 12'h000;                              // RULE11
                fs_r[k]   <= {DATA_W{1'b0}};
                filt_r[k] <= {DATA_W{1'b0}};
                max_r[k]  <= {DATA_W{1'b0}};
                min_r[k]  <= {DATA_W{1'b0}};
                raw_r[k]  <= {DATA_W{1'b0}};
            end
            for (k = 0; k < 16; k = k + 1) begin
                name_r[k] <= 32'h00000000;
            end
            primed_r <= 4'h0;
            mm_ok_r  <= 4'h0;                                      // RULE15
            ot_r     <= 4'h0;
        end else if (i_ce) begin
            // new reading: filter step and extreme capture
            if (take) begin
                raw_r[c]  <= i_rdg_value;
                filt_r[c] <= f_new;
                // filter off leaves it unprimed so re-enabling starts fresh
                primed_r[c] <= en_r[c];
                ot_r[c]     <= over;                               // RULE10
                if (!mm_ok_r[c]) begin
                    max_r[c]   <= f_new;                           // RULE12
                    min_r[c]   <= f_new;
                    mm_ok_r[c] <= 1'b1;
                end else begin
                    if ($signed(f_new) > $signed(max_r[c])) begin
                        max_r[c] <= f_new;                         // RULE14
                    end
                    if ($signed(f_new) < $signed(min_r[c])) begin
                        min_r[c] <= f_new;                         // RULE14
                    end
                end
            end
            // parameter writes win over a reading of the same input
            if (wr_cfg) begin
                en_r[bch]   <= i_wdata[`IRF_CFG_EN_BIT];
                unit_r[bch] <= i_wdata[`IRF_CFG_UNIT_LSB +: 2];    // RULE13
                pts_r[bch]  <= pts_c;
                win_r[bch]  <= win_c;
            end
            if (wr_lim) begin
                lim_r[bch] <= lim_c;                               // RULE10
                ot_r[bch]  <= 1'b0;
            end
            if (wr_fs) begin
                fs_r[bch] <= i_wdata[DATA_W-1:0];
            end
            if (par_chg) begin
                primed_r[bch] <= 1'b0;                             // RULE19
                mm_ok_r[bch]  <= 1'b0;                             // RULE15
            end
            if (wr_name) begin
                // last byte kept zero: 15 characters and a terminator
                if (bidx[1:0] == 2'h3) begin
                    name_r[{bch, bidx[1:0]}] <= {8'h00, i_wdata[23:0]};
                end else begin
                    name_r[{bch, bidx[1:0]}] <= i_wdata;           // RULE17
                end
            end
            if (wr_mmr) begin
                mm_ok_r <= mm_ok_r & ~i_wdata[3:0];                // RULE15
            end
        end
    end

    // ======================================================================
    // output streams, shutdown and interrupt
    // ======================================================================
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_res_valid <= 1'b0;
            o_res_chan  <= 2'h0;
            o_res_value <= {DATA_W{1'b0}};
            o_res_units <= `IRF_UNIT_RST;
            o_ctl_valid <= 1'b0;
            o_ctl_chan  <= 2'h0;
            o_ctl_value <= {DATA_W{1'b0}};
            o_shutdown  <= 1'b0;
            o_irq       <= 1'b0;
        end else if (i_ce) begin
            o_res_valid <= take;                                   // RULE2
            o_ctl_valid <= take;
            if (take) begin
                o_res_chan  <= c;
                o_res_value <= f_new;                              // RULE3
                o_res_units <= unit_r[c];                          // RULE16
                o_ctl_chan  <= c;
                o_ctl_value <= i_rdg_value;                        // RULE3
            end
            // one cycle behind the flags: shuts down every control output
            o_shutdown <= |ot_r;                                   // RULE9
            o_irq      <= |(status_r & mask_r);
        end
    end

    // sticky status: hardware set wins over a write-one clear
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_r <= {`IRF_ST_W{1'b0}};
            mask_r   <= {`IRF_ST_W{1'b0}};
        end else if (i_ce) begin
            status_r <= (status_r &
                         ~(wr_st ? i_wdata[`IRF_ST_W-1:0] :
                           {`IRF_ST_W{1'b0}})) |
                        ({`IRF_ST_W{take}} &
                         (({{(`IRF_ST_W-4){1'b0}}, 4'h1} << c) |
                          ({{(`IRF_ST_W-4){1'b0}}, {3'h0, over}}
                           << (`IRF_ST_OT_LSB + c)) |
                          ({{(`IRF_ST_W-4){1'b0}},
                            {3'h0, en_r[c] & primed_r[c] & jump}}
                           << (`IRF_ST_RS_LSB + c))));
            if (wr_mask) begin
                mask_r <= i_wdata[`IRF_ST_W-1:0];
            end
        end
    end

    // ======================================================================
    // read data, one cycle after the strobe, zero otherwise
    // ======================================================================
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h00000000;
        end else if (i_ce) begin
            o_rdata <= 32'h00000000;
            if (i_re) begin
                if (i_addr == `IRF_ADDR_STATUS) begin
                    o_rdata <= {20'h00000, status_r};
                end else if (i_addr == `IRF_ADDR_MASK) begin
                    o_rdata <= {20'h00000, mask_r};
                end else if (i_addr == `IRF_ADDR_SHUT) begin
                    o_rdata <= {27'h0, o_shutdown, ot_r};
                end else if (is_glob) begin
                    o_rdata <= 32'h00000000;
                end else if (bidx == `IRF_IDX_CFG) begin
                    o_rdata <= {12'h000, win_r[bch], 1'b0, pts_r[bch],
                                5'h00, unit_r[bch], en_r[bch]};
                end else if (bidx == `IRF_IDX_LIMIT) begin
                    o_rdata <= {20'h00000, lim_r[bch]};
                end else if (bidx == `IRF_IDX_FSCALE) begin
                    o_rdata <= {{(32-DATA_W){1'b0}}, fs_r[bch]};
                end else if (bidx == `IRF_IDX_FILT) begin
                    o_rdata <= {{(32-DATA_W){1'b0}}, filt_r[bch]};
                end else if (bidx == `IRF_IDX_MAX) begin
                    o_rdata <= {{(32-DATA_W){1'b0}}, max_r[bch]};
                end else if (bidx == `IRF_IDX_MIN) begin
                    o_rdata <= {{(32-DATA_W){1'b0}}, min_r[bch]};
                end else if (bidx == `IRF_IDX_RAW) begin
                    o_rdata <= {{(32-DATA_W){1'b0}}, raw_r[bch]};
                end else if (bidx[3:2] == 2'h2) begin
                    o_rdata <= name_r[{bch, bidx[1:0]}];
                end else begin
                    o_rdata <= 32'h00000000;
                end
            end
        end
    end

endmodule // irf_top

// [verification/irf_top_props.sv]
// checker for result timing and register read port of the reading filter
`timescale 1ns/1ps
`include "irf_regs.vh"
module irf_top_props #(
    parameter DATA_W = 24
) (
    input wire                   i_clk,
    input wire                   i_reset_n,
    input wire                   i_ce,
    input wire [`IRF_ADDR_W-1:0] i_addr,
    input wire [31:0]            i_wdata,
    input wire                   i_we,
    input wire                   i_re,
    input wire [31:0]            o_rdata,
    input wire                   i_rdg_valid,
    input wire [1:0]             i_rdg_chan,
    input wire [DATA_W-1:0]      i_rdg_value,
    input wire [DATA_W-1:0]      i_rdg_kelvin,
    input wire                   o_res_valid,
    input wire [1:0]             o_res_chan,
    input wire [DATA_W-1:0]      o_res_value,
    input wire [1:0]             o_res_units,
    input wire                   o_ctl_valid,
    input wire [1:0]             o_ctl_chan,
    input wire [DATA_W-1:0]      o_ctl_value,
    input wire                   o_shutdown,
    input wire                   o_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ======================================================================
    // reading in, result out
    // ======================================================================
    // a bus write in the same cycle may drop a reading, so it is excluded
    sequence rdg_taken;
        i_ce && i_rdg_valid && !i_we;
    endsequence
    sequence res_out;
        o_res_valid && o_ctl_valid;
    endsequence

    a_res_one_cycle: assert property (rdg_taken |=> res_out)
        else $error("reading gave no result one cycle later");
    a_res_pulse_only: assert property (
        o_res_valid |-> $past(i_rdg_valid))
        else $error("result without a reading");
    a_ctl_raw_value: assert property (
        o_ctl_valid |-> o_ctl_value == $past(i_rdg_value))
        else $error("control value is not the raw reading");
    a_res_chan_match: assert property (
        o_res_valid |->
        o_res_chan == $past(i_rdg_chan) && o_ctl_chan == o_res_chan)
        else $error("result channel differs from reading channel");
    a_ctl_res_pair: assert property (o_res_valid == o_ctl_valid)
        else $error("filtered and raw results not paired");
    a_res_data_hold: assert property (
        !o_res_valid |-> $stable(o_res_value) && $stable(o_ctl_value))
        else $error("result data moved without a new result");

    // ======================================================================
    // shutdown and read port
    // ======================================================================
    // shutdown only moves after a result or a limit write
    a_shut_follows_cause: assert property (
        $changed(o_shutdown) |-> $past(o_ctl_valid) || $past(i_we, 2))
        else $error("shutdown changed without a cause");
    a_rdata_idle_zero: assert property (!$past(i_re) |-> o_rdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
endmodule // irf_top_props

bind irf_top irf_top_props #(.DATA_W(DATA_W)) u_props (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
    .i_rdg_valid(i_rdg_valid), .i_rdg_chan(i_rdg_chan),
    .i_rdg_value(i_rdg_value), .i_rdg_kelvin(i_rdg_kelvin),
    .o_res_valid(o_res_valid), .o_res_chan(o_res_chan),
    .o_res_value(o_res_value), .o_res_units(o_res_units),
    .o_ctl_valid(o_ctl_valid), .o_ctl_chan(o_ctl_chan),
    .o_ctl_value(o_ctl_value), .o_shutdown(o_shutdown), .o_irq(o_irq));

// [verification/irf_frontend_model.sv]
// behavioural measurement front end that delivers readings
`timescale 1ns/1ps
module irf_frontend_model (
    input  wire        i_clk,
    output logic       o_valid,
    output logic [1:0] o_chan,
    output logic [23:0] o_value,
    output logic [23:0] o_kelvin
);
    // ======================================================================
    // one reading per call, lines scrambled once it is gone
    // ======================================================================
    initial begin
        o_valid = 1'b0;
        o_chan = 2'h0;
        o_value = 24'h0;
        o_kelvin = 24'h0;
    end

    // inverted lines afterwards, so stale data can never look valid
    task automatic send(input logic [1:0] ch, input logic [23:0] v,
                        input logic [23:0] k);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_chan <= ch;
        o_value <= v;
        o_kelvin <= k;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_chan <= ~ch;
        o_value <= ~v;
        o_kelvin <= ~k;
    endtask
endmodule // irf_frontend_model

// [verification/irf_top_tb.sv]
// self-checking bench: filter, window restart, max/min, over-temperature
`timescale 1ns/1ps
module irf_top_tb;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        i_ce = 1'b1;
    logic [8:0]  i_addr = 9'h0;
    logic [31:0] i_wdata = 32'h0;
    logic        i_we = 1'b0;
    logic        i_re = 1'b0;
    logic [31:0] o_rdata, rd;
    logic        rv, cv, o_shutdown, o_irq;
    logic [1:0]  rch, cch, runits, fch;
    logic [23:0] rval, cval, fval, fkel;
    logic        fvld;
    int          bad_count = 0;
    int          compares = 0;

    always #2 i_clk = ~i_clk;

    irf_frontend_model fe (.i_clk(i_clk), .o_valid(fvld), .o_chan(fch),
        .o_value(fval), .o_kelvin(fkel));
    irf_top #(.DATA_W(24)) DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
        .i_re(i_re), .o_rdata(o_rdata), .i_rdg_valid(fvld),
        .i_rdg_chan(fch), .i_rdg_value(fval), .i_rdg_kelvin(fkel),
        .o_res_valid(rv), .o_res_chan(rch), .o_res_value(rval),
        .o_res_units(runits), .o_ctl_valid(cv), .o_ctl_chan(cch),
        .o_ctl_value(cval), .o_shutdown(o_shutdown), .o_irq(o_irq));

    // ======================================================================
    // shared tasks
    // ======================================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_we <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask
    task automatic rdc(input logic [8:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_re <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    // reading, then filtered and raw results in the answer cycle
    task automatic rdg(input logic [1:0] ch, input logic [23:0] v,
                       input logic [23:0] k, input logic [23:0] f);
        fe.send(ch, v, k);
        #1;
        chk({rv, cv, rch, rval}, {2'b11, ch, f});
        chk({cch, cval}, {ch, v});
    endtask
    function automatic logic [31:0] cfg(logic en, logic [1:0] u,
                                        logic [6:0] n, logic [3:0] w);
        return {12'h0, w, 1'b0, n, 5'h0, u, en};
    endfunction
    task automatic conclude;
        $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // cut a hang short
    initial begin
        #200000;
        bad_count++;
        conclude();
    end

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rdc(9'h000, cfg(1'b0, 2'h0, 7'h08, 4'hA));
        rdc(9'h004, 32'h0);
        rdc(9'h110, 32'h0);
        rdg(2'h0, 24'h000064, 24'h0, 24'h000064);
        $display("test reset and passthrough done");
        // point and window clamps at both ends
        wr(9'h080, cfg(1'b0, 2'h0, 7'h64, 4'hF));
        rdc(9'h080, cfg(1'b0, 2'h0, 7'h40, 4'hA));
        wr(9'h080, cfg(1'b0, 2'h0, 7'h01, 4'h0));
        rdc(9'h080, cfg(1'b0, 2'h0, 7'h02, 4'h1));
        $display("test clamps done");
        // ch1 filter on, N=2, window 10% of 1000 gives a 100 count window
        wr(9'h048, 32'd1000);
        wr(9'h040, cfg(1'b1, 2'h0, 7'h02, 4'hA));
        rdg(2'h1, 24'd100, 24'h0, 24'd100);
        rdg(2'h1, 24'd120, 24'h0, 24'd110);
        rdg(2'h1, 24'd108, 24'h0, 24'd109);
        wr(9'h100, 32'h00000FFF);
        rdg(2'h1, 24'd300, 24'h0, 24'd300);
        rdc(9'h100, 32'h00000202);
        rdc(9'h04C, 32'd300);
        wr(9'h040, cfg(1'b1, 2'h0, 7'h04, 4'hA));
        rdg(2'h1, 24'd150, 24'h0, 24'd150);
        rdg(2'h1, 24'd158, 24'h0, 24'd152);
        $display("test filter done");
        // ch2 units and max/min with signed values
        wr(9'h080, cfg(1'b0, 2'h1, 7'h08, 4'hA));
        rdg(2'h2, 24'd50, 24'h0, 24'd50);
        chk({30'h0, runits}, 32'h1);
        rdg(2'h2, 24'hFFFFEC, 24'h0, 24'hFFFFEC);
        rdg(2'h2, 24'd30, 24'h0, 24'd30);
        rdc(9'h090, 32'd50);
        rdc(9'h094, 32'h00FFFFEC);
        wr(9'h10C, 32'h00000004);
        rdg(2'h2, 24'd7, 24'h0, 24'd7);
        rdc(9'h090, 32'd7);
        rdc(9'h094, 32'd7);
        $display("test max min done");
        // over-temperature: ch3 at 10 K, ch0 disabled with a huge kelvin
        wr(9'h0C4, 32'h00000FFF);
        rdc(9'h0C4, 32'h00000BB7);
        wr(9'h0C4, 32'd10);
        wr(9'h100, 32'h00000FFF);
        wr(9'h104, 32'h00000080);
        rdg(2'h0, 24'd1, 24'hFFFFFF, 24'd1);
        @(posedge i_clk);
        #1 chk({30'h0, o_shutdown, o_irq}, 32'h0);
        rdg(2'h3, 24'd11, 24'h000B00, 24'd11);
        @(posedge i_clk);
        #1 chk({30'h0, o_shutdown, o_irq}, 32'h3);
        rdc(9'h108, 32'h00000018);
        rdg(2'h3, 24'd10, 24'h000A00, 24'd10);
        @(posedge i_clk);
        #1 chk({30'h0, o_shutdown, o_irq}, 32'h1);
        wr(9'h100, 32'h00000080);
        @(posedge i_clk);
        #1 chk({31'h0, o_irq}, 32'h0);
        $display("test over temperature done");
        // enable low: the reading is ignored and every output holds
        @(posedge i_clk);
        i_ce <= 1'b0;
        fe.send(2'h1, 24'd999, 24'h0);
        i_ce <= 1'b1;
        #1 chk({rv, rval}, {1'b0, 24'd10});
        rdc(9'h04C, 32'd152);
        $display("test clock enable done");
        conclude();
    end
endmodule // irf_top_tb
